// File: verilog/psr_pkg.sv
// Package: map, field layout and reset values of the primary status block
package psr_pkg;

  // APB address width and data width
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CMD = 8'h04;     // Command register
  localparam logic [7:0] IDX_STS = 8'h06;     // Primary bus status
  localparam logic [7:0] IDX_IRQ_STS = 8'h20; // Sticky event status
  localparam logic [7:0] IDX_IRQ_MSK = 8'h21; // Event interrupt mask

  // Reset values
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] STS_RESET = 16'h0290;
  localparam logic [15:0] IRQ_STS_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MSK_RESET = 16'h0000;

  // Command bits that software may write
  localparam logic [15:0] CMD_WR_MASK = 16'h0367;
  // Command field positions
  localparam int CMD_SERR_EN = 8;   // Primary system error driver enable
  localparam int CMD_PAR_RESP = 6;  // Parity error response enable

  // Status flags cleared by writing one
  localparam logic [15:0] STS_W1C_MASK = 16'hf900;
  // Status field positions
  localparam int STS_PAR_DET = 15;  // Detected parity error
  localparam int STS_SERR_SIG = 14; // Signalled system error
  localparam int STS_MABT_RCV = 13; // Received master abort
  localparam int STS_TABT_RCV = 12; // Received target abort
  localparam int STS_TABT_SIG = 11; // Signalled target abort
  localparam int STS_SEL_LO = 9;    // Target select timing, low bit
  localparam int STS_DPAR = 8;      // Data parity error as master
  localparam int STS_FAST_B2B = 7;  // Fast back-to-back capable
  localparam int STS_USER_FEAT = 6; // User feature support
  localparam int STS_FAST_CLK = 5;  // Fast clock strap level
  localparam int STS_CAP_LIST = 4;  // Capabilities list present

  // Constant status fields
  localparam logic [1:0] SEL_TIMING_MEDIUM = 2'b01;
  localparam logic FAST_B2B_VAL = 1'b1;
  localparam logic USER_FEAT_VAL = 1'b0;
  localparam logic CAP_LIST_VAL = 1'b1;

endpackage

// File: verilog/psr_sync2.sv
// Two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module psr_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);

  // First stage, read only by the second stage
  logic meta_r;
  logic meta_nxt;
  // Second stage
  logic sync_r;
  logic sync_nxt;

  // Next values: plain shift
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Stage registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule
`default_nettype wire

// File: verilog/psr_apb_phase.sv
// APB phase decoder: setup, write and read strobes, ready and error
`timescale 1ns/1ps
`default_nettype none
module psr_apb_phase (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic addr_hit,
  output logic setup_stb,
  output logic wr_stb,
  output logic rd_stb,
  output logic pready,
  output logic pslverr
);

  // Address hit caught in the setup cycle
  logic hit_r;
  logic hit_nxt;
  // Access cycle of a transfer
  logic access;

  // Phase decode; every access completes in one cycle
  always_comb begin
    setup_stb = psel && !penable;
    access = psel && penable;
    pready = access;
    wr_stb = access && pwrite && hit_r;
    rd_stb = access && !pwrite && hit_r;
    pslverr = access && !hit_r;
    hit_nxt = setup_stb ? addr_hit : hit_r;
  end

  // Hit register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

endmodule
`default_nettype wire

// File: verilog/psr_status_top.sv
// Primary bus status register bank with command enables and interrupt
//
// Operation
// R1: Writing one clears a flag; zero keeps
// R2: Status at index 06h, 16 bits, 0290h
// R3: Bit 15 sets on any parity error
// R4: Bit 14 sets on system error if enabled
// R5: Bit 13 sets on received master abort
// R6: Bit 12 sets on received target abort
// R7: Bit 11 sets on signalled target abort
// R8: Bits 10-9 read 01b, writes ignored
// R9: Bit 8 needs fault line, mastership, enable
// R10: Bit 7 always reads one
// R11: Bit 6 always reads zero
// R12: Bit 5 reads the fast clock strap
// R13: Bit 4 always reads one
// R14: Bits 3-0 read zero, writes ignored
// R15: Command bit 8 enables system error driver
// R16: Command bit 6 enables parity response, off
// R17: Set event wins over same-cycle clear
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module psr_status_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_clock_strap,
  input wire logic parity_detect_evt,
  input wire logic serr_signal_evt,
  input wire logic master_abort_rcvd_evt,
  input wire logic target_abort_rcvd_evt,
  input wire logic target_abort_sig_evt,
  input wire logic primary_parity_fault_line,
  input wire logic bridge_data_master,
  output logic serr_driver_en,
  output logic parity_resp_en,
  output logic irq
);

  // Timing overview
  //   Setup edge: address and read data are captured
  //   Access edge: writes and clears take effect
  //   No wait states; pready follows the access phase
  //   An event on the setup edge shows on the next read
  //   Event status clears only what the read returned
  //   Upper half of every data word reads zero
  //   Unmapped places answer with an error and zero data

  // Byte address of a register index
  function automatic logic [11:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction

  // True when a byte address selects a mapped register
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == reg_addr(psr_pkg::IDX_CMD)) ||
                (a == reg_addr(psr_pkg::IDX_STS)) ||
                (a == reg_addr(psr_pkg::IDX_IRQ_STS)) ||
                (a == reg_addr(psr_pkg::IDX_IRQ_MSK));
  endfunction

  // Bus phase strobes
  logic setup_stb;
  logic wr_stb;
  logic rd_stb;
  // Synchronised strap level
  logic strap_s;

  // Command register and next value
  logic [15:0] cmd_r;
  logic [15:0] cmd_nxt;
  // Sticky status flags and next value
  logic [15:0] sts_r;
  logic [15:0] sts_nxt;
  // Interrupt event status and mask
  logic [15:0] irq_sts_r;
  logic [15:0] irq_sts_nxt;
  logic [15:0] irq_msk_r;
  logic [15:0] irq_msk_nxt;
  // Read data register and next value
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  // Address latched in setup, used in access
  logic [11:0] addr_r;
  logic [11:0] addr_nxt;

  // Hardware events in status layout
  logic [15:0] evt_set;
  // Write data gated by byte strobes
  logic [15:0] wr_bytes;
  // Full status word as read
  logic [15:0] sts_view;
  // Register selects in the access cycle
  logic sel_cmd;
  logic sel_sts;
  logic sel_irq_sts;
  logic sel_irq_msk;

  // Bus phase decoder
  psr_apb_phase u_phase (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .addr_hit(is_mapped(paddr)),
    .setup_stb(setup_stb),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .pready(pready),
    .pslverr(pslverr)
  );

  // Strap pin crosses in through two flops
  // Level is read live, not latched at reset
  psr_sync2 u_strap (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(fast_clock_strap),
    .sync_out(strap_s)
  );

  // Access-cycle selects from the setup address
  always_comb begin
    sel_cmd = (addr_r == reg_addr(psr_pkg::IDX_CMD));
    sel_sts = (addr_r == reg_addr(psr_pkg::IDX_STS));
    sel_irq_sts = (addr_r == reg_addr(psr_pkg::IDX_IRQ_STS));
    sel_irq_msk = (addr_r == reg_addr(psr_pkg::IDX_IRQ_MSK));
    wr_bytes = pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}};
    addr_nxt = setup_stb ? paddr : addr_r;
  end

  // Event collection into status bit positions
  always_comb begin
    // Positions that no event drives stay zero
    evt_set = 16'h0000;
    // Any detected parity error
    evt_set[psr_pkg::STS_PAR_DET] = parity_detect_evt; // R3
    // System error counts only while its driver is enabled
    evt_set[psr_pkg::STS_SERR_SIG] =
      serr_signal_evt && cmd_r[psr_pkg::CMD_SERR_EN]; // R4
    // Own primary cycle ended by master abort
    evt_set[psr_pkg::STS_MABT_RCV] = master_abort_rcvd_evt; // R5
    // Own primary cycle ended by target abort
    evt_set[psr_pkg::STS_TABT_RCV] = target_abort_rcvd_evt; // R6
    // Bridge as target ended a cycle with target abort
    evt_set[psr_pkg::STS_TABT_SIG] = target_abort_sig_evt; // R7
    // Data parity: fault line, bridge mastering, response on
    evt_set[psr_pkg::STS_DPAR] = primary_parity_fault_line &&
      bridge_data_master && cmd_r[psr_pkg::CMD_PAR_RESP]; // R9
  end

  // Command register: only writable bits change
  always_comb begin
    cmd_nxt = cmd_r;
    if (wr_stb && sel_cmd) begin
      // Read-only command bits keep their value
      cmd_nxt = (cmd_r & ~psr_pkg::CMD_WR_MASK) |
                (wr_bytes & psr_pkg::CMD_WR_MASK); // R15 R16
    end
  end

  // Status flags: clear by one, event set wins
  always_comb begin
    sts_nxt = sts_r;
    if (wr_stb && sel_sts) begin
      // Zero bits leave flags alone
      sts_nxt = sts_r & ~(wr_bytes & psr_pkg::STS_W1C_MASK); // R1
    end
    // Set after clear so a same-cycle event survives
    sts_nxt = (sts_nxt | evt_set) & psr_pkg::STS_W1C_MASK; // R17
  end

  // Status word as software sees it
  always_comb begin
    // Flags over a zero background; reserved bits stay zero
    sts_view = sts_r & psr_pkg::STS_W1C_MASK; // R14
    sts_view[psr_pkg::STS_SEL_LO +: 2] = psr_pkg::SEL_TIMING_MEDIUM; // R8
    sts_view[psr_pkg::STS_FAST_B2B] = psr_pkg::FAST_B2B_VAL; // R10
    sts_view[psr_pkg::STS_USER_FEAT] = psr_pkg::USER_FEAT_VAL; // R11
    sts_view[psr_pkg::STS_FAST_CLK] = strap_s; // R12
    sts_view[psr_pkg::STS_CAP_LIST] = psr_pkg::CAP_LIST_VAL; // R13
  end

  // Interrupt mask register
  always_comb begin
    irq_msk_nxt = irq_msk_r;
    if (wr_stb && sel_irq_msk) begin
      // Only flag positions can be enabled
      irq_msk_nxt = wr_bytes & psr_pkg::STS_W1C_MASK;
    end
  end

  // Interrupt status: read clears reported bits, events win
  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (rd_stb && sel_irq_sts) begin
      // Clear only what the captured read data showed
      irq_sts_nxt = irq_sts_r & ~prdata_r[15:0];
    end
    irq_sts_nxt = irq_sts_nxt | evt_set; // R17
  end

  // Read data captured in setup for the access cycle
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_stb) begin
      prdata_nxt = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == reg_addr(psr_pkg::IDX_CMD)) begin
          // Command word as stored
          prdata_nxt[15:0] = cmd_r;
        end else if (paddr == reg_addr(psr_pkg::IDX_STS)) begin
          // Events landing this edge are caught on the next read
          prdata_nxt[15:0] = sts_view; // R2
        end else if (paddr == reg_addr(psr_pkg::IDX_IRQ_STS)) begin
          // Event status before this read clears it
          prdata_nxt[15:0] = irq_sts_r;
        end else if (paddr == reg_addr(psr_pkg::IDX_IRQ_MSK)) begin
          // Mask readback
          prdata_nxt[15:0] = irq_msk_r;
        end else begin
          // Unmapped reads return zero with an error
          prdata_nxt = 32'h0000_0000;
        end
      end
    end
  end

  // Command register state; enables start off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r <= psr_pkg::CMD_RESET; // R16
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // Sticky flags; only clearable positions are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_r <= psr_pkg::STS_RESET & psr_pkg::STS_W1C_MASK; // R2
    end else begin
      sts_r <= sts_nxt;
    end
  end

  // Event status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_r <= psr_pkg::IRQ_STS_RESET;
    end else begin
      irq_sts_r <= irq_sts_nxt;
    end
  end

  // Event mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_msk_r <= psr_pkg::IRQ_MSK_RESET;
    end else begin
      irq_msk_r <= irq_msk_nxt;
    end
  end

  // Read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Setup address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 12'h000;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // Outputs
  assign prdata = prdata_r;
  // Primary system error driver follows its enable
  assign serr_driver_en = cmd_r[psr_pkg::CMD_SERR_EN]; // R15
  // Parity response enable for the bus logic
  assign parity_resp_en = cmd_r[psr_pkg::CMD_PAR_RESP]; // R16
  // Level interrupt while any unmasked event bit is set
  assign irq = |(irq_sts_r & irq_msk_r);

endmodule
`default_nettype wire

// File: dv/psr_status_checker.sv
// Checker for the primary bus status register bank
`timescale 1ns/1ps
`default_nettype none
module psr_status_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic parity_detect_evt,
  input wire logic master_abort_rcvd_evt,
  input wire logic primary_parity_fault_line,
  input wire logic bridge_data_master,
  input wire logic serr_driver_en,
  input wire logic parity_resp_en
);
  // Access phase of a status read or command write
  wire rd_sts = psel && penable && !pwrite && paddr == 12'h018;
  wire wr_cmd = psel && penable && pwrite && paddr == 12'h010;
  // Decoded places
  wire mapped = paddr == 12'h010 || paddr == 12'h018 ||
    paddr == 12'h080 || paddr == 12'h084;
  // Master data parity condition
  wire dpar_cond = primary_parity_fault_line && bridge_data_master &&
    parity_resp_en;
  wire serr_bit = pwdata[8];
  wire par_bit = pwdata[6];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rsvd_zero: assert property (rd_sts |-> prdata[3:0] == 4'h0 &&
    prdata[31:16] == 16'h0) else $error("reserved bits set");
  chk_sel_timing: assert property (rd_sts |-> prdata[10:9] == 2'b01)
    else $error("select timing wrong");
  chk_fixed_bits: assert property (rd_sts |-> prdata[7] &&
    !prdata[6] && prdata[4]) else $error("fixed bits wrong");
  chk_par_sticky: assert property (rd_sts &&
    $past(parity_detect_evt, 2) |-> prdata[15]) else $error("bit 15 lost");
  chk_mabt_sticky: assert property (rd_sts &&
    $past(master_abort_rcvd_evt, 2) |-> prdata[13]) else $error("bit 13");
  chk_dpar_gate: assert property (rd_sts &&
    $past(dpar_cond, 2) |-> prdata[8]) else $error("bit 8 lost");
  chk_serr_cmd: assert property (wr_cmd && pstrb[1] |=>
    serr_driver_en == $past(serr_bit)) else $error("serr enable");
  chk_par_cmd: assert property (wr_cmd && pstrb[0] |-> ##1
    parity_resp_en == $past(par_bit)) else $error("parity enable");
  chk_unmapped_err: assert property (psel && penable && !mapped
    |-> pready && pslverr) else $error("unmapped not refused");
endmodule
bind psr_status_top psr_status_checker chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .parity_detect_evt(parity_detect_evt),
  .master_abort_rcvd_evt(master_abort_rcvd_evt),
  .primary_parity_fault_line(primary_parity_fault_line),
  .bridge_data_master(bridge_data_master),
  .serr_driver_en(serr_driver_en), .parity_resp_en(parity_resp_en));
`default_nettype wire

// File: dv/psr_evt_model.sv
// Model of the primary bus logic that raises bridge events
`timescale 1ns/1ps
`default_nettype none
module psr_evt_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [6:0] fire,
  output logic [6:0] evt
);
  // Each request drives its event line for one clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= 7'h00;
    end else begin
      evt <= fire;
    end
  end
endmodule
`default_nettype wire

// File: dv/test_psr_status_top.sv
// Self-checking bench for the primary bus status register bank
`timescale 1ns/1ps
`default_nettype none
module test_psr_status_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fast_clock_strap = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [6:0] fire = 7'h00;
  logic [6:0] evt;
  logic [31:0] prdata, r;
  logic [32:0] e;
  logic pready, pslverr, serr_driver_en, parity_resp_en, irq;
  logic [32:0] q[$]; // Expected {pslverr, prdata}
  int fails = 0;
  int cmp_count = 0;
  int seed = 34502;
  int i;
  int bl[6] = '{15, 14, 13, 12, 11, 8}; // Clearable flags
  always #5 pclk = ~pclk;
  psr_evt_model model (.pclk(pclk), .presetn(presetn), .fire(fire),
    .evt(evt));
  psr_status_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_clock_strap(fast_clock_strap), .parity_detect_evt(evt[0]),
    .serr_signal_evt(evt[1]), .master_abort_rcvd_evt(evt[2]),
    .target_abort_rcvd_evt(evt[3]), .target_abort_sig_evt(evt[4]),
    .primary_parity_fault_line(evt[5]), .bridge_data_master(evt[6]),
    .serr_driver_en(serr_driver_en), .parity_resp_en(parity_resp_en),
    .irq(irq));
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  // One transfer from an edge; f fires events at the access edge
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    input logic [3:0] s, input logic [6:0] f);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    fire <= f;
    @(posedge pclk);
    penable <= 1'b1;
    fire <= 7'h00;
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    r = $random(seed);
    apb(a, 1'b0, r, 4'hf, 7'h00);
  endtask
  task ev(input logic [6:0] f);
    fire <= f;
    @(posedge pclk);
    fire <= 7'h00;
    @(posedge pclk);
  endtask
  // Read data against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk("read", {pslverr, prdata}, q.pop_front());
    end
  end
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h018, 33'h290);
    rd(12'h01c, 33'h100000000);
    apb(12'h018, 1'b1, 32'hffffffff, 4'hf, 7'h00);
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      ev({r[1:0], 3'h0, r[2], 1'b0});
    end
    ev(7'h62);
    rd(12'h018, 33'h290);
    apb(12'h010, 1'b1, 32'h140, 4'h3, 7'h00);
    chk("serr_en", {32'h0, serr_driver_en}, 33'h1);
    chk("par_en", {32'h0, parity_resp_en}, 33'h1);
    rd(12'h010, 33'h140);
    ev(7'h7f);
    rd(12'h018, 33'hfb90);
    apb(12'h018, 1'b1, 32'hffff, 4'h0, 7'h00);
    apb(12'h018, 1'b1, 32'h0, 4'h3, 7'h00);
    rd(12'h018, 33'hfb90);
    e = 33'hfb90;
    foreach (bl[k]) begin
      apb(12'h018, 1'b1, 32'h1 << bl[k], 4'h3, 7'h00);
      e = e & ~(33'h1 << bl[k]);
      rd(12'h018, e);
    end
    apb(12'h018, 1'b1, 32'h8000, 4'h3, 7'h01);
    rd(12'h018, 33'h8290);
    apb(12'h018, 1'b1, 32'h8000, 4'h3, 7'h00);
    $display("test flags done");
    fast_clock_strap <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h018, 33'h2b0);
    presetn <= 1'b0;
    @(posedge pclk);
    chk("serr_en", {32'h0, serr_driver_en}, 33'h0);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(12'h010, 33'h0);
    rd(12'h018, 33'h2b0);
    apb(12'h084, 1'b1, 32'h8000, 4'h3, 7'h00);
    ev(7'h04);
    repeat (2) @(posedge pclk);
    chk("irq", {32'h0, irq}, 33'h0);
    ev(7'h01);
    repeat (2) @(posedge pclk);
    chk("irq", {32'h0, irq}, 33'h1);
    rd(12'h084, 33'h8000);
    rd(12'h080, 33'ha000);
    rd(12'h080, 33'h0);
    chk("irq", {32'h0, irq}, 33'h0);
    rd(12'h018, 33'ha2b0);
    $display("test irq done");
    wrap_up();
  end
endmodule
`default_nettype wire
